/* tcc_channel_ctrl.sv */
// telco channel control: hold remote, talkback, listen, remote input setup
`timescale 1ns/10ps
module tcc_channel_ctrl
#(
   parameter int DB_CYC = tcc_pkg::DB_CYC,
   parameter int HOLD_CYC = tcc_pkg::HOLD_CYC,
   parameter int BLANK_CYC = tcc_pkg::BLANK_CYC,
   parameter int FLASH_CYC = tcc_pkg::FLASH_CYC,
   parameter int BLINK_CYC = tcc_pkg::BLINK_CYC
)
(
   // clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [tcc_pkg::PADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // panel and channel state
   input wire logic programButton,
   input wire logic auditionButton,
   input wire logic listenButton,
   input wire logic onButton,
   input wire logic lineHoldButton,
   input wire logic channelOn,
   input wire logic faderUp,
   input wire logic gpInput,
   // option links, high when fitted or in second position
   input wire logic holdStyleLink,
   input wire logic returnMuteLink,
   input wire logic startStyleLink,
   input wire logic listenCancelLink,
   input wire logic returnBusSelectA,
   input wire logic returnBusSelectB,
   // remotes and routing
   output logic hybridHold,
   output logic startOut,
   output logic returnMute,
   output logic talkbackMix,
   output logic returnBus1,
   output logic returnBus2,
   output logic busLinkMismatch,
   output logic listenSelect,
   output logic faderForceOpen,
   output logic hybridIndicator,
   // lamps
   output logic lampOn,
   output logic lampListen,
   output logic lampAud,
   output logic lampPgm
);
   ////////////////////////////////////////////////////////////////////////
   logic [tcc_pkg::NPIN-1:0] rawPins;
   logic [tcc_pkg::NPIN-1:0] pins;
   logic [tcc_pkg::NPIN-1:0] press;
   logic [tcc_pkg::NPIN-1:0] pinsDly_ff;
   logic [3:0] cfg;
   logic cfgMom;
   logic cfgAh;
   tcc_pkg::tcc_action_t cfgAct;
   logic nvWr;
   logic [3:0] nvData;
   logic apbWrCfg;
   tcc_nv_if nvBus();

   assign rawPins = {returnBusSelectB, returnBusSelectA, listenCancelLink,
      startStyleLink, returnMuteLink, holdStyleLink, gpInput, faderUp,
      channelOn, lineHoldButton, onButton, listenButton, auditionButton,
      programButton};

   tcc_pin_filter #(.W(tcc_pkg::NPIN), .DB_CYC(DB_CYC)) u_filter
   (
      .clk(clk),
      .reset_n(reset_n),
      .pinRaw(rawPins),
      .pinLevel(pins)
   );

   tcc_nv_store u_store
   (
      .clk(clk),
      .reset_n(reset_n),
      .port(nvBus.store)
   );

   assign nvBus.wrEn = nvWr;
   assign nvBus.wrData = nvData;
   assign cfg = nvBus.rdData;
   assign cfgMom = cfg[tcc_pkg::CFG_MOM_BIT];
   assign cfgAh = cfg[tcc_pkg::CFG_AH_BIT];
   assign cfgAct = tcc_pkg::tcc_action_t'(cfg[tcc_pkg::CFG_ACT_LSB +: 2]);
   // one event per debounced press
   assign press = pins & ~pinsDly_ff;

   ////////////////////////////////////////////////////////////////////////
   // setup sequence
   tcc_pkg::tcc_state_t state_ff;
   tcc_pkg::tcc_state_t nxt_state;
   logic [2:0] audCnt_ff;
   logic [2:0] nxt_audCnt;
   logic [1:0] sel_ff;
   logic [1:0] nxt_sel;
   logic [31:0] tmr_ff;
   logic [31:0] nxt_tmr;
   logic [31:0] sub_ff;
   logic [31:0] nxt_sub;
   logic blink_ff;
   logic nxt_blink;
   logic pgmHeld;

   assign pgmHeld = pins[tcc_pkg::PIN_PGM];

   always_comb
   begin
      nxt_state = state_ff;
      nxt_audCnt = audCnt_ff;
      nxt_sel = sel_ff;
      nxt_tmr = tmr_ff;
      nxt_sub = sub_ff;
      nxt_blink = blink_ff;
      nvWr = 1'b0;
      nvData = cfg;
      unique case (state_ff)
         tcc_pkg::ST_NORMAL:
         begin
            if (!pgmHeld)
               nxt_audCnt = 3'h0;
            else if (press[tcc_pkg::PIN_AUD])
            begin
               if (audCnt_ff == tcc_pkg::ENTRY_PRESSES - 3'h1)
               begin
                  nxt_state = tcc_pkg::ST_BLANK;
                  nxt_audCnt = 3'h0;
                  nxt_tmr = 32'h0000_0000;
               end
               else
                  nxt_audCnt = audCnt_ff + 3'h1;
            end
            if (apbWrCfg)
            begin
               nvWr = 1'b1;
               nvData = pwdata[3:0];
            end
         end
         tcc_pkg::ST_BLANK:
         begin
            if (tmr_ff >= 32'(BLANK_CYC - 1))
            begin
               nxt_state = tcc_pkg::ST_FUNC;
               nxt_sel = cfg[1:0];
            end
            else
               nxt_tmr = tmr_ff + 32'h0000_0001;
         end
         tcc_pkg::ST_FUNC:
         begin
            if (press[tcc_pkg::PIN_ON])
            begin
               nvWr = 1'b1;
               nvData = {cfg[3:2], sel_ff};
               nxt_state = tcc_pkg::ST_FLASH;
               nxt_tmr = 32'h0000_0000;
               nxt_sub = 32'h0000_0000;
               nxt_blink = 1'b1;
            end
            else if (press[tcc_pkg::PIN_PGM])
               nxt_sel = sel_ff + 2'h1;
         end
         tcc_pkg::ST_FLASH:
         begin
            if (sub_ff >= 32'(BLINK_CYC - 1))
            begin
               nxt_sub = 32'h0000_0000;
               nxt_blink = !blink_ff;
            end
            else
               nxt_sub = sub_ff + 32'h0000_0001;
            if (tmr_ff >= 32'(FLASH_CYC - 1))
            begin
               nxt_state = tcc_pkg::ST_ACTION;
               nxt_sel = cfg[3:2];
            end
            else
               nxt_tmr = tmr_ff + 32'h0000_0001;
         end
         tcc_pkg::ST_ACTION:
         begin
            if (press[tcc_pkg::PIN_ON])
            begin
               nvWr = 1'b1;
               nvData = {sel_ff, cfg[1:0]};
               nxt_state = tcc_pkg::ST_NORMAL;
            end
            else if (press[tcc_pkg::PIN_PGM])
               nxt_sel = sel_ff + 2'h1;
         end
         default:
            nxt_state = tcc_pkg::ST_NORMAL;
      endcase
   end

   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         state_ff <= tcc_pkg::ST_NORMAL;
         audCnt_ff <= 3'h0;
         sel_ff <= 2'h0;
         tmr_ff <= 32'h0000_0000;
         sub_ff <= 32'h0000_0000;
         blink_ff <= 1'b0;
      end
      else
      begin
         state_ff <= nxt_state;
         audCnt_ff <= nxt_audCnt;
         sel_ff <= nxt_sel;
         tmr_ff <= nxt_tmr;
         sub_ff <= nxt_sub;
         blink_ff <= nxt_blink;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // channel state: listen, line hold, remote input, hold pulse
   logic listenSel_ff;
   logic nxt_listen;
   logic lineOn_ff;
   logic nxt_lineOn;
   logic gpDly_ff;
   logic gpToggle_ff;
   logic nxt_gpToggle;
   logic holdCondDly_ff;
   logic [31:0] holdCnt_ff;
   logic [31:0] nxt_holdCnt;
   logic normal;
   logic cancelCond;
   logic gpAsserted;
   logic gpActive;
   logic holdCond;
   logic holdRise;
   logic tbEn;

   assign normal = state_ff == tcc_pkg::ST_NORMAL;
   assign cancelCond = pins[tcc_pkg::PIN_LK_CANCEL]
      && pins[tcc_pkg::PIN_CHON] && pins[tcc_pkg::PIN_FADER];
   assign gpAsserted = pins[tcc_pkg::PIN_GP] == cfgAh;
   // momentary remote pulses toggle; a latching remote is followed as is
   assign gpActive = cfgMom ? gpToggle_ff : gpAsserted;
   assign holdCond = (pins[tcc_pkg::PIN_CHON] && pins[tcc_pkg::PIN_FADER])
      || listenSel_ff;
   assign holdRise = holdCond && !holdCondDly_ff;
   assign tbEn = listenSel_ff || (cfgAct == tcc_pkg::ACT_TALK && gpActive);

   always_comb
   begin
      nxt_listen = listenSel_ff;
      if (cancelCond)
         nxt_listen = 1'b0;
      else if (normal && press[tcc_pkg::PIN_LIST])
         nxt_listen = !listenSel_ff;
      nxt_lineOn = lineOn_ff ^ press[tcc_pkg::PIN_LHOLD];
      // edge taken on the pin itself: no false toggle after reset or on a
      // polarity change, and only a momentary remote toggles
      nxt_gpToggle = gpToggle_ff ^ (cfgMom && gpAsserted
         && pins[tcc_pkg::PIN_GP] != gpDly_ff);
      nxt_holdCnt = 32'h0000_0000;
      if (!pins[tcc_pkg::PIN_LK_HOLD])
      begin
         if (holdRise)
            nxt_holdCnt = 32'(HOLD_CYC - 1);
         else if (holdCnt_ff != 32'h0000_0000)
            nxt_holdCnt = holdCnt_ff - 32'h0000_0001;
      end
   end

   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         pinsDly_ff <= '0;
         listenSel_ff <= 1'b0;
         lineOn_ff <= 1'b0;
         gpDly_ff <= 1'b0;
         gpToggle_ff <= 1'b0;
         holdCondDly_ff <= 1'b0;
         holdCnt_ff <= 32'h0000_0000;
      end
      else
      begin
         pinsDly_ff <= pins;
         listenSel_ff <= nxt_listen;
         lineOn_ff <= nxt_lineOn;
         gpDly_ff <= pins[tcc_pkg::PIN_GP];
         gpToggle_ff <= nxt_gpToggle;
         holdCondDly_ff <= holdCond;
         holdCnt_ff <= nxt_holdCnt;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // registered outputs
   logic [13:0] out_ff;
   logic [13:0] nxt_out;
   logic holdNext;

   always_comb
   begin
      holdNext = pins[tcc_pkg::PIN_LK_HOLD] ? holdCond
         : (holdRise || holdCnt_ff != 32'h0000_0000);
      nxt_out[0] = holdNext;
      // continuous start follows the button; normal start follows line state
      nxt_out[1] = pins[tcc_pkg::PIN_LK_START] ? pins[tcc_pkg::PIN_LHOLD]
         : lineOn_ff;
      nxt_out[2] = pins[tcc_pkg::PIN_LK_MUTE] && tbEn;
      nxt_out[3] = !pins[tcc_pkg::PIN_LK_MUTE] && tbEn;
      // mismatched links select neither bus rather than both
      nxt_out[4] = !pins[tcc_pkg::PIN_BUS_A] && !pins[tcc_pkg::PIN_BUS_B];
      nxt_out[5] = pins[tcc_pkg::PIN_BUS_A] && pins[tcc_pkg::PIN_BUS_B];
      nxt_out[6] = pins[tcc_pkg::PIN_BUS_A]
         ^ pins[tcc_pkg::PIN_BUS_B];
      nxt_out[7] = listenSel_ff;
      nxt_out[8] = cfgAct == tcc_pkg::ACT_FADER && gpActive;
      nxt_out[9] = cfgAct == tcc_pkg::ACT_IND && gpActive;
      unique case (state_ff)
         tcc_pkg::ST_FUNC, tcc_pkg::ST_ACTION:
            nxt_out[13:10] = {1'b0, 1'b0, sel_ff[1], sel_ff[0]};
         tcc_pkg::ST_FLASH:
            nxt_out[13:10] = {blink_ff, 3'h0};
         tcc_pkg::ST_BLANK:
            nxt_out[13:10] = 4'h0;
         default:
            nxt_out[13:10] = {pins[tcc_pkg::PIN_PGM], pins[tcc_pkg::PIN_AUD],
               listenSel_ff, pins[tcc_pkg::PIN_CHON]};
      endcase
   end

   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
         out_ff <= 14'h0000;
      else
         out_ff <= nxt_out;
   end

   assign hybridHold = out_ff[0];
   assign startOut = out_ff[1];
   assign returnMute = out_ff[2];
   assign talkbackMix = out_ff[3];
   assign returnBus1 = out_ff[4];
   assign returnBus2 = out_ff[5];
   assign busLinkMismatch = out_ff[6];
   assign listenSelect = out_ff[7];
   assign faderForceOpen = out_ff[8];
   assign hybridIndicator = out_ff[9];
   assign lampOn = out_ff[10];
   assign lampListen = out_ff[11];
   assign lampAud = out_ff[12];
   assign lampPgm = out_ff[13];

   ////////////////////////////////////////////////////////////////////////
   // apb slave, zero wait states
   logic [31:0] rdata_ff;
   logic [31:0] nxt_rdata;
   logic ready_ff;
   logic err_ff;
   logic setupPhase;
   logic hit;

   assign setupPhase = psel && !penable;
   assign hit = paddr == tcc_pkg::ADDR_CFG || paddr == tcc_pkg::ADDR_STAT;
   // software may rewrite the setup only outside the panel sequence
   assign apbWrCfg = psel && penable && ready_ff && pwrite && !err_ff
      && paddr == tcc_pkg::ADDR_CFG;

   always_comb
   begin
      nxt_rdata = 32'h0000_0000;
      if (setupPhase && !pwrite && paddr == tcc_pkg::ADDR_CFG)
         nxt_rdata[3:0] = cfg;
      else if (setupPhase && !pwrite && paddr == tcc_pkg::ADDR_STAT)
      begin
         nxt_rdata[tcc_pkg::STAT_LISTEN_BIT] = listenSel_ff;
         nxt_rdata[tcc_pkg::STAT_HOLD_BIT] = out_ff[0];
         nxt_rdata[tcc_pkg::STAT_SETUP_BIT] = !normal;
         nxt_rdata[tcc_pkg::STAT_GP_BIT] = gpActive;
         nxt_rdata[tcc_pkg::STAT_MISM_BIT] = out_ff[6];
      end
   end

   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         rdata_ff <= 32'h0000_0000;
         ready_ff <= 1'b0;
         err_ff <= 1'b0;
      end
      else
      begin
         rdata_ff <= nxt_rdata;
         ready_ff <= setupPhase;
         err_ff <= setupPhase && !hit;
      end
   end

   assign prdata = rdata_ff;
   assign pready = ready_ff;
   assign pslverr = err_ff;

   ////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);

   property p_hold_on;
      pins[tcc_pkg::PIN_LK_HOLD] && pins[tcc_pkg::PIN_CHON]
         && pins[tcc_pkg::PIN_FADER] |=> hybridHold;
   endproperty
   a_hold_on: assert property (p_hold_on)
      else $error("hold missing with channel live");

   property p_hold_listen;
      pins[tcc_pkg::PIN_LK_HOLD] && listenSel_ff |=> hybridHold;
   endproperty
   a_hold_listen: assert property (p_hold_listen)
      else $error("hold missing with listen selected");

   property p_hold_pulse;
      !pins[tcc_pkg::PIN_LK_HOLD] && holdCnt_ff == 32'h0000_0000
         && !holdRise |=> !hybridHold;
   endproperty
   a_hold_pulse: assert property (p_hold_pulse)
      else $error("momentary hold outlived its pulse");

   property p_mute;
      tbEn |=> $past(pins[tcc_pkg::PIN_LK_MUTE]) ? returnMute && !talkbackMix
         : talkbackMix && !returnMute;
   endproperty
   a_mute: assert property (p_mute)
      else $error("talkback mute or mix wrong");

   property p_start;
      pins[tcc_pkg::PIN_LK_START]
         |=> startOut == $past(pins[tcc_pkg::PIN_LHOLD]);
   endproperty
   a_start: assert property (p_start)
      else $error("continuous start does not follow button");

   property p_listen_toggle;
      normal && press[tcc_pkg::PIN_LIST] && !cancelCond
         |=> listenSel_ff != $past(listenSel_ff)
         ##1 listenSelect == $past(listenSel_ff);
   endproperty
   a_listen_toggle: assert property (p_listen_toggle)
      else $error("listen did not toggle");

   property p_listen_cancel;
      cancelCond |=> !listenSel_ff;
   endproperty
   a_listen_cancel: assert property (p_listen_cancel)
      else $error("listen not cancelled by fader");

   property p_bus;
      !pins[tcc_pkg::PIN_BUS_A] && !pins[tcc_pkg::PIN_BUS_B]
         |=> returnBus1 && !returnBus2 && !busLinkMismatch;
   endproperty
   a_bus: assert property (p_bus)
      else $error("return bus 1 not selected");

   sequence s_fifth_aud;
      normal && pgmHeld && press[tcc_pkg::PIN_AUD] && audCnt_ff == 3'h4;
   endsequence
   sequence s_blanked;
      state_ff == tcc_pkg::ST_BLANK ##1 !lampOn && !lampListen && !lampPgm;
   endsequence
   property p_entry;
      s_fifth_aud |=> s_blanked;
   endproperty
   a_entry: assert property (p_entry)
      else $error("setup not entered after fifth press");

   property p_func_lamps;
      state_ff == tcc_pkg::ST_FUNC |=> lampOn == $past(sel_ff[0])
         && lampListen == $past(sel_ff[1]) && !lampAud;
   endproperty
   a_func_lamps: assert property (p_func_lamps)
      else $error("function lamps wrong");

   property p_wrap;
      state_ff == tcc_pkg::ST_FUNC && press[tcc_pkg::PIN_PGM]
         && !press[tcc_pkg::PIN_ON] && sel_ff == 2'h3 |=> sel_ff == 2'h0;
   endproperty
   a_wrap: assert property (p_wrap)
      else $error("option did not wrap");

   property p_store;
      state_ff == tcc_pkg::ST_FUNC && press[tcc_pkg::PIN_ON]
         |-> nvWr ##1 state_ff == tcc_pkg::ST_FLASH ##1 lampPgm;
   endproperty
   a_store: assert property (p_store)
      else $error("function not stored");

   property p_exit;
      state_ff == tcc_pkg::ST_ACTION && press[tcc_pkg::PIN_ON]
         |-> nvWr ##1 normal ##1 cfg[3:2] == $past(sel_ff, 2);
   endproperty
   a_exit: assert property (p_exit)
      else $error("action not stored on exit");
endmodule

/* tcc_nv_if.sv */
// carrier between the control logic and the setup store
`timescale 1ns/10ps
interface tcc_nv_if;
   logic wrEn;
   logic [3:0] wrData;
   logic [3:0] rdData;
   modport client (output wrEn, output wrData, input rdData);
   modport store (input wrEn, input wrData, output rdData);
endinterface

/* tcc_nv_store.sv */
// setup store for the remote input function and action
`timescale 1ns/10ps
module tcc_nv_store
(
   // clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // access
   tcc_nv_if.store port
);
   logic [3:0] mem_ff;
   logic [3:0] rd_ff;
   logic [3:0] nxt_mem;
   // stands in for the non-volatile cell; a real part loads it at power-up
   always_comb
   begin
      nxt_mem = port.wrEn ? port.wrData : mem_ff;
   end
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         mem_ff <= tcc_pkg::CFG_RST;
         rd_ff <= tcc_pkg::CFG_RST;
      end
      else
      begin
         mem_ff <= nxt_mem;
         rd_ff <= nxt_mem;
      end
   end
   assign port.rdData = rd_ff;
endmodule

/* tcc_panel_model.sv */
// front panel operator model driving the channel buttons
`timescale 1ns/10ps
module tcc_panel_model
(
   // clock
   input wire logic clk,
   // buttons: program, audition, listen, on, line hold
   output logic [4:0] buttons
);
   initial buttons = 5'h0_0;
   task automatic hold(input int i, input logic v);
   begin
      @(posedge clk);
      buttons[i] <= v;
   end
   endtask
   // presses outlast the debounce so each counts once
   task automatic push(input int i);
   begin
      hold(i, 1'b1);
      repeat (15) @(posedge clk);
      hold(i, 1'b0);
      repeat (15) @(posedge clk);
   end
   endtask
endmodule

/* tcc_pin_filter.sv */
// three-flop synchroniser and debounce filter for every pin input
`timescale 1ns/10ps
module tcc_pin_filter
#(
   parameter int W = 14,
   parameter int DB_CYC = 1000
)
(
   // clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // pins
   input wire logic [W-1:0] pinRaw,
   output logic [W-1:0] pinLevel
);
   for (genvar i = 0; i < W; i++)
   begin : g_bit
      logic [2:0] sync_ff;
      logic [31:0] cnt_ff;
      logic [31:0] nxt_cnt;
      logic lvl_ff;
      logic nxt_lvl;
      // a change must hold steady for the whole window before it counts
      always_comb
      begin
         nxt_cnt = 32'h0000_0000;
         nxt_lvl = lvl_ff;
         if (sync_ff[1] == sync_ff[2] && sync_ff[2] != lvl_ff)
         begin
            if (cnt_ff >= 32'(DB_CYC - 1))
               nxt_lvl = sync_ff[2];
            else
               nxt_cnt = cnt_ff + 32'h0000_0001;
         end
      end
      always_ff @(posedge clk or negedge reset_n)
      begin
         if (!reset_n)
         begin
            sync_ff <= 3'h0;
            cnt_ff <= 32'h0000_0000;
            lvl_ff <= 1'b0;
         end
         else
         begin
            sync_ff <= {sync_ff[1:0], pinRaw[i]};
            cnt_ff <= nxt_cnt;
            lvl_ff <= nxt_lvl;
         end
      end
      assign pinLevel[i] = lvl_ff;
   end
endmodule

/* tcc_pkg.sv */
// shared constants and types for the telco channel control block
package tcc_pkg;
   // clock and timing, times in ms
   localparam int CLK_KHZ = 32'h0001_86A0;
   localparam int DB_MS = 32'h0000_000A;
   localparam int HOLD_MS = 32'h0000_00C8;
   localparam int BLANK_MS = 32'h0000_01F4;
   localparam int FLASH_MS = 32'h0000_03E8;
   localparam int BLINK_MS = 32'h0000_0032;
   localparam int DB_CYC = DB_MS * CLK_KHZ;
   localparam int HOLD_CYC = HOLD_MS * CLK_KHZ;
   localparam int BLANK_CYC = BLANK_MS * CLK_KHZ;
   localparam int FLASH_CYC = FLASH_MS * CLK_KHZ;
   localparam int BLINK_CYC = BLINK_MS * CLK_KHZ;
   localparam logic [2:0] ENTRY_PRESSES = 3'h5;
   // register map
   localparam int PADDR_W = 12;
   localparam logic [11:0] ADDR_CFG = 12'h000;
   localparam logic [11:0] ADDR_STAT = 12'h004;
   localparam logic [3:0] CFG_RST = 4'h0;
   localparam int CFG_MOM_BIT = 0;
   localparam int CFG_AH_BIT = 1;
   localparam int CFG_ACT_LSB = 2;
   localparam int STAT_LISTEN_BIT = 0;
   localparam int STAT_HOLD_BIT = 1;
   localparam int STAT_SETUP_BIT = 2;
   localparam int STAT_GP_BIT = 3;
   localparam int STAT_MISM_BIT = 4;
   // pin vector positions
   localparam int PIN_PGM = 0;
   localparam int PIN_AUD = 1;
   localparam int PIN_LIST = 2;
   localparam int PIN_ON = 3;
   localparam int PIN_LHOLD = 4;
   localparam int PIN_CHON = 5;
   localparam int PIN_FADER = 6;
   localparam int PIN_GP = 7;
   localparam int PIN_LK_HOLD = 8;
   localparam int PIN_LK_MUTE = 9;
   localparam int PIN_LK_START = 10;
   localparam int PIN_LK_CANCEL = 11;
   localparam int PIN_BUS_A = 12;
   localparam int PIN_BUS_B = 13;
   localparam int NPIN = 14;
   typedef enum logic [2:0] {ST_NORMAL, ST_BLANK, ST_FUNC, ST_FLASH,
      ST_ACTION} tcc_state_t;
   typedef enum logic [1:0] {ACT_NONE, ACT_TALK, ACT_FADER, ACT_IND}
      tcc_action_t;
endpackage

/* test_telco_channel_control_logic.sv */
// self-checking bench for the telco channel control block
`timescale 1ns/10ps
module test_telco_channel_control_logic;
   logic clk = 0;
   logic reset_n, psel, penable, pwrite, gp, chOn, fader;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd, rnd;
   logic pready, pslverr, err;
   logic lkHold, lkMute, lkStart, lkCancel, busA, busB;
   logic hHold, start, rMute, tbMix, bus1, bus2, mism, listen, ffo, hInd;
   logic lOn, lList, lAud, lPgm;
   logic [4:0] btn;
   int failures = 0, comparisons = 0, lit;
   always #5 clk = ~clk;
   tcc_panel_model op_u (.clk(clk), .buttons(btn));
   tcc_channel_ctrl #(.DB_CYC(4), .HOLD_CYC(20), .BLANK_CYC(10),
      .FLASH_CYC(40), .BLINK_CYC(5)) dut_u (.clk(clk), .reset_n(reset_n),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .programButton(btn[0]), .auditionButton(btn[1]),
      .listenButton(btn[2]), .onButton(btn[3]), .lineHoldButton(btn[4]),
      .channelOn(chOn), .faderUp(fader), .gpInput(gp),
      .holdStyleLink(lkHold), .returnMuteLink(lkMute),
      .startStyleLink(lkStart), .listenCancelLink(lkCancel),
      .returnBusSelectA(busA), .returnBusSelectB(busB), .hybridHold(hHold),
      .startOut(start), .returnMute(rMute), .talkbackMix(tbMix),
      .returnBus1(bus1), .returnBus2(bus2), .busLinkMismatch(mism),
      .listenSelect(listen), .faderForceOpen(ffo), .hybridIndicator(hInd),
      .lampOn(lOn), .lampListen(lList), .lampAud(lAud), .lampPgm(lPgm));
   ////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
   begin
      comparisons++;
      if (got !== exp)
      begin
         failures++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   end
   endtask
   task automatic end_sim;
   begin
      if (failures == 0 && comparisons > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   end
   endtask
   task automatic w(input int n);
      repeat (n) @(posedge clk);
   endtask
   // master holds the request until pready is seen at an edge
   task automatic apb(input logic wr, input logic [11:0] a,
      input logic [31:0] d);
   begin
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1)
         @(posedge clk);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   end
   endtask
   function automatic logic [2:0] busExp(input logic a, input logic b);
      return {a != b, a & b, ~a & ~b};
   endfunction
   ////////////////////////////////////////////////////////////////////////
   initial
   begin
      void'($urandom(32'h4bd2));
      reset_n <= 1'b0;
      {psel, penable, pwrite, paddr, pwdata} <= '0;
      {gp, chOn, fader, lkStart, lkCancel, busA, busB} <= '0;
      {lkHold, lkMute} <= 2'b11;
      w(6);
      reset_n <= 1'b1;
      for (int i = 0; i < 6; i++)
      begin
         busA <= 1'($urandom);
         busB <= 1'($urandom);
         w(15);
         chk({mism, bus2, bus1}, busExp(busA, busB));
      end
      chOn <= 1'b1;
      fader <= 1'b1;
      w(15);
      chk(hHold, 1'b1);
      chOn <= 1'b0;
      op_u.push(2);
      chk({listen, hHold, rMute, tbMix}, 4'b1110);
      lkMute <= 1'b0;
      w(15);
      chk({rMute, tbMix}, 2'b01);
      op_u.push(2);
      chk(listen, 1'b0);
      lkCancel <= 1'b1;
      op_u.push(2);
      chk(listen, 1'b1);
      chOn <= 1'b1;
      w(15);
      chk(listen, 1'b0);
      chOn <= 1'b0;
      lkHold <= 1'b0;
      w(15);
      chOn <= 1'b1;
      w(14);
      chk(hHold, 1'b1);
      w(28);
      chk(hHold, 1'b0);
      lkStart <= 1'b1;
      op_u.hold(4, 1'b1);
      w(15);
      chk(start, 1'b1);
      op_u.hold(4, 1'b0);
      w(15);
      chk(start, 1'b0);
      lkStart <= 1'b0;
      w(15);
      chk(start, 1'b1);
      chOn <= 1'b0;
      fader <= 1'b0;
      op_u.hold(0, 1'b1);
      repeat (4) op_u.push(1);
      op_u.hold(1, 1'b1);
      w(15);
      chk({lOn, lList, lAud, lPgm}, 4'h0);
      op_u.hold(1, 1'b0);
      op_u.hold(0, 1'b0);
      w(15);
      apb(1'b0, 12'h004, 32'h0000_0000);
      chk(rd[2], 1'b1);
      for (int k = 1; k < 7; k++)
      begin
         op_u.push(0);
         chk({lAud, lList, lOn}, k % 4);
      end
      op_u.push(3);
      // program lamp must blink, neither dark nor steady, while storing
      lit = 0;
      repeat (45)
      begin
         @(posedge clk);
         lit += lPgm;
      end
      chk(lit > 3 && lit < 13, 1'b1);
      op_u.push(0);
      chk({lAud, lList, lOn}, 3'h1);
      op_u.push(3);
      apb(1'b0, 12'h000, 32'h0000_0000);
      chk(rd, 32'h0000_0006);
      gp <= 1'b1;
      w(15);
      chk(tbMix, 1'b1);
      rnd = $urandom;
      apb(1'b1, 12'h000, {rnd[31:4], 4'hA});
      apb(1'b0, 12'h000, 32'h0000_0000);
      chk(rd, 32'h0000_000A);
      w(2);
      chk({hInd, ffo}, 2'b01);
      apb(1'b1, 12'h000, 32'h0000_000E);
      w(3);
      chk({hInd, ffo}, 2'b10);
      apb(1'b1, 12'h000, 32'h0000_0007);
      w(3);
      chk(tbMix, 1'b0);
      gp <= 1'b0;
      w(15);
      gp <= 1'b1;
      w(15);
      chk(tbMix, 1'b1);
      gp <= 1'b0;
      w(15);
      chk(tbMix, 1'b1);
      apb(1'b1, 12'h000, 32'h0000_0004);
      w(3);
      chk(tbMix, 1'b1);
      gp <= 1'b1;
      w(15);
      chk(tbMix, 1'b0);
      apb(1'b0, 12'h00C, 32'h0000_0000);
      chk(err, 1'b1);
      chk(rd, 32'h0000_0000);
      end_sim;
   end
   // whole run is about a thousand cycles
   initial
   begin
      #100000;
      failures++;
      end_sim;
   end
endmodule
